// File: design/snpc_cmd_frame.sv
// instruction framing, busy gating and array write protection of the serial nand
// Overview of operation
// (R1) Field 0000 protects nothing; codes 0001..1001 protect 1..256 blocks at top or bottom.
// (R2) Field codes 101x and 11xx protect the whole array whatever the other bits hold.
// (R3) Erase or program touching any protected block is ignored and starts nothing.
// (R4) A falling chip select starts a new instruction.
// (R5) The first byte after chip select falls is the opcode.
// (R6) Input bits are taken on the serial clock rising edge, most significant first.
// (R7) An opcode may be followed by address, data, dummy bytes or a mix of them.
// (R8) A rising chip select completes the instruction.
// (R9) Read-type instructions may end after any number of bits.
// (R10) Write, program or erase frames not ending on a byte boundary are discarded.
// (R11) Busy stays high for the whole program, erase, bad-block and page read operation.
// (R12) While busy, only status reads and the identification read are served.
// (R13) The full opcode set is recognised; unknown opcodes are ignored to frame end.
// (R14) Identification read returns one maker byte then two part bytes, also while busy.
// (R15) Program refused for protection sets the program failure flag.
// (R16) Erase refused for protection sets the erase failure flag.
// (R17) Busy drops to zero once the internal operation ends.
module snpc_cmd_frame
	import snpc_pkg::*;
#(
	parameter logic [7:0]  MAKER_CODE = 8'h5A,  // arbitrary value
	parameter logic [15:0] PART_CODE  = 16'h3C81 // arbitrary value
)
(
	input  wire logic              sys_clk,
	input  wire logic              reset_n,
	input  wire logic              chipSelectN,
	input  wire logic              serialClk,
	input  wire logic              serialDataIn,
	output logic                   serialDataOut,
	output logic                   serialDataOutEn,
	input  wire logic              topBottomSelect,
	input  wire logic              protectFieldBit3,
	input  wire logic              protectFieldBit2,
	input  wire logic              protectFieldBit1,
	input  wire logic              protectFieldBit0,
	output logic                   busy,
	output logic                   programFail,
	output logic                   eraseFail,
	output logic                   opStart,
	output snpc_op_t               opKind,
	output logic [PAGE_W-1:0]      opPageAddr,
	output logic                   frameDropped
);

	snpc_protect_if pif();

	logic [1:0]          csSync;
	logic [1:0]          sclkSync;
	logic [1:0]          sdiSync;
	logic                csPrev;
	logic                sclkPrev;
	logic                csFall;
	logic                csRise;
	logic                sclkRise;
	logic                sclkFall;
	logic                frameActive;
	logic [7:0]          shiftNext;
	logic [2:0]          idxNext;
	logic [7:0]          srSel;
	logic [7:0]          statusByte;
	logic [7:0]          protectByte;
	snpc_state_t         state_reg, state_next;
	logic [7:0]          shift_reg, shift_next;
	logic [2:0]          bitCnt_reg, bitCnt_next;
	logic [2:0]          byteCnt_reg, byteCnt_next;
	logic [7:0]          opcode_reg, opcode_next;
	logic [7:0]          srAddr_reg, srAddr_next;
	logic [7:0]          pageHi_reg, pageHi_next;
	logic [7:0]          pageLo_reg, pageLo_next;
	logic [7:0]          outShift_reg, outShift_next;
	logic                outEn_reg, outEn_next;
	logic [OP_CNT_W-1:0] busyCnt_reg, busyCnt_next;
	logic                busy_reg, busy_next;
	logic                pfail_reg, pfail_next;
	logic                efail_reg, efail_next;
	logic                opStart_reg, opStart_next;
	snpc_op_t            opKind_reg, opKind_next;
	logic [PAGE_W-1:0]   opPage_reg, opPage_next;
	logic                drop_reg, drop_next;

	// two-stage synchronisers and edge history for the pins
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			csSync   <= 2'h3;
			sclkSync <= 2'h0;
			sdiSync  <= 2'h0;
			csPrev   <= 1'b1;
			sclkPrev <= 1'b0;
		end else begin
			csSync   <= {csSync[0], chipSelectN};
			sclkSync <= {sclkSync[0], serialClk};
			sdiSync  <= {sdiSync[0], serialDataIn};
			csPrev   <= csSync[1];
			sclkPrev <= sclkSync[1];
		end
	end

	// edge events on the synchronised pins
	assign csFall      = csPrev & ~csSync[1]; // see (R4)
	assign csRise      = ~csPrev & csSync[1]; // see (R8)
	assign sclkRise    = sclkSync[1] & ~sclkPrev;
	assign sclkFall    = ~sclkSync[1] & sclkPrev;
	assign frameActive = (state_reg == ST_OPCODE) || (state_reg == ST_BODY);
	assign shiftNext   = {shift_reg[6:0], sdiSync[1]}; // see (R6)
	assign idxNext     = (byteCnt_reg == 3'h7) ? byteCnt_reg : byteCnt_reg + 3'h1;

	// protection query on the captured page address
	assign pif.topBottomSelect = topBottomSelect;
	assign pif.protectField    = {protectFieldBit3, protectFieldBit2, protectFieldBit1,
		protectFieldBit0};
	assign pif.queryBlock      = {pageHi_reg[6:0], pageLo_reg[7:6]};
	assign pif.wholeChip       = (opcode_reg == OPC_CHIP_ER_A) || (opcode_reg == OPC_CHIP_ER_B);

	snpc_protect_decode u_decode (
		.pif (pif.decoder)
	);

	// reply bytes for status reads
	always_comb begin
		statusByte = 8'h00;
		statusByte[PFAIL_BIT] = pfail_reg;
		statusByte[EFAIL_BIT] = efail_reg;
		statusByte[BUSY_BIT]  = busy_reg;
		protectByte = {1'b0, pif.protectField, topBottomSelect, 2'h0};
	end

	// byte to shift out at reply index idx
	function automatic logic [7:0] replyByte(input logic [7:0] op, input logic [2:0] idx,
		input logic [7:0] sr);
		replyByte = 8'h00;
		if (op == OPC_READ_ID) begin
			case (idx)
				3'h2: replyByte = MAKER_CODE;      // see (R14)
				3'h3: replyByte = PART_CODE[15:8]; // see (R14)
				3'h4: replyByte = PART_CODE[7:0];  // see (R14)
				default: replyByte = 8'h00;
			endcase
		end else if ((op == OPC_RD_SR_A) || (op == OPC_RD_SR_B)) begin
			replyByte = (sr[7:4] == SR_STATUS_SEL) ? statusByte : protectByte;
		end
	endfunction

	// next-state logic of framing, protection and busy timing
	always_comb begin
		state_next    = state_reg;
		shift_next    = shift_reg;
		bitCnt_next   = bitCnt_reg;
		byteCnt_next  = byteCnt_reg;
		opcode_next   = opcode_reg;
		srAddr_next   = srAddr_reg;
		pageHi_next   = pageHi_reg;
		pageLo_next   = pageLo_reg;
		outShift_next = outShift_reg;
		outEn_next    = outEn_reg;
		busyCnt_next  = busyCnt_reg;
		busy_next     = busy_reg;
		pfail_next    = pfail_reg;
		efail_next    = efail_reg;
		opStart_next  = 1'b0;
		opKind_next   = opKind_reg;
		opPage_next   = opPage_reg;
		drop_next     = 1'b0;
		srSel         = srAddr_reg;
		// internal operation timer
		if (busy_reg) begin
			busyCnt_next = busyCnt_reg - 1'b1;
			if (busyCnt_reg == 1'b1) begin
				busy_next = 1'b0; // see (R17)
			end
		end
		if (csFall) begin
			state_next    = ST_OPCODE; // see (R4)
			bitCnt_next   = 3'h0;
			byteCnt_next  = 3'h0;
			outEn_next    = 1'b0;
			outShift_next = 8'h00;
		end else if (csRise) begin
			state_next = ST_IDLE; // see (R8)
			outEn_next = 1'b0;
			// read types need nothing here and may stop on any bit, see (R9)
			if ((state_reg == ST_BODY) && actsAtEnd(opcode_reg)) begin
				if ((bitCnt_reg != 3'h0) || (byteCnt_reg < neededBytes(opcode_reg))) begin
					drop_next = 1'b1; // see (R10)
				end else begin
					case (opcode_reg)
						OPC_RESET: begin
							pfail_next = 1'b0;
							efail_next = 1'b0;
						end
						OPC_BLK_ERASE, OPC_CHIP_ER_A, OPC_CHIP_ER_B: begin
							if (pif.hit) begin
								efail_next = 1'b1; // see (R3) (R16)
							end else begin
								efail_next   = 1'b0;
								opStart_next = 1'b1;
								opKind_next  = OP_ERASE;
							end
						end
						OPC_PROG_EXEC: begin
							if (pif.hit) begin
								pfail_next = 1'b1; // see (R3) (R15)
							end else begin
								pfail_next   = 1'b0;
								opStart_next = 1'b1;
								opKind_next  = OP_PROGRAM;
							end
						end
						OPC_PAGE_READ: begin
							opStart_next = 1'b1;
							opKind_next  = OP_PAGE_READ;
						end
						OPC_BBM: begin
							opStart_next = 1'b1;
							opKind_next  = OP_BBM;
						end
						default: opStart_next = 1'b0;
					endcase
					if (opStart_next) begin
						opPage_next  = {pageHi_reg, pageLo_reg};
						busy_next    = 1'b1; // see (R11)
						busyCnt_next = OP_CNT_LOAD;
					end
				end
			end
		end else if (frameActive && sclkRise) begin
			shift_next  = shiftNext;
			bitCnt_next = bitCnt_reg + 3'h1;
			if (bitCnt_reg == 3'h7) begin
				byteCnt_next = idxNext;
				// argument capture by byte position, see (R7)
				case (byteCnt_reg)
					3'h0: begin
						opcode_next = shiftNext; // see (R5)
						if (!isKnown(shiftNext) || (busy_reg && !allowedBusy(shiftNext))) begin
							state_next = ST_DROP; // see (R12) (R13)
							drop_next  = 1'b1;
						end else begin
							state_next = ST_BODY;
						end
					end
					3'h1: begin
						srAddr_next = shiftNext;
						srSel       = shiftNext;
						if (opcode_reg == OPC_BBM) begin
							pageHi_next = shiftNext;
						end
					end
					3'h2: begin
						if (opcode_reg == OPC_BBM) begin
							pageLo_next = shiftNext;
						end else begin
							pageHi_next = shiftNext;
						end
					end
					3'h3: begin
						if (opcode_reg != OPC_BBM) begin
							pageLo_next = shiftNext;
						end
					end
					default: srSel = srAddr_reg;
				endcase
				// load the next reply byte for identification and status reads
				if ((byteCnt_reg != 3'h0) && (idxNext >= IDX_REPLY) &&
					((opcode_reg == OPC_READ_ID) || (opcode_reg == OPC_RD_SR_A) ||
					(opcode_reg == OPC_RD_SR_B))) begin
					outShift_next = replyByte(opcode_reg, idxNext, srSel);
					outEn_next    = 1'b1;
				end
			end
		end else if (frameActive && sclkFall && (bitCnt_reg != 3'h0)) begin
			outShift_next = {outShift_reg[6:0], 1'b0};
		end
	end

	// state registers
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			state_reg    <= ST_IDLE;
			shift_reg    <= 8'h00;
			bitCnt_reg   <= 3'h0;
			byteCnt_reg  <= 3'h0;
			opcode_reg   <= 8'h00;
			srAddr_reg   <= 8'h00;
			pageHi_reg   <= 8'h00;
			pageLo_reg   <= 8'h00;
			outShift_reg <= 8'h00;
			outEn_reg    <= 1'b0;
			busyCnt_reg  <= '0;
			busy_reg     <= 1'b0;
			pfail_reg    <= 1'b0;
			efail_reg    <= 1'b0;
			opStart_reg  <= 1'b0;
			opKind_reg   <= OP_NONE;
			opPage_reg   <= '0;
			drop_reg     <= 1'b0;
		end else begin
			state_reg    <= state_next;
			shift_reg    <= shift_next;
			bitCnt_reg   <= bitCnt_next;
			byteCnt_reg  <= byteCnt_next;
			opcode_reg   <= opcode_next;
			srAddr_reg   <= srAddr_next;
			pageHi_reg   <= pageHi_next;
			pageLo_reg   <= pageLo_next;
			outShift_reg <= outShift_next;
			outEn_reg    <= outEn_next;
			busyCnt_reg  <= busyCnt_next;
			busy_reg     <= busy_next;
			pfail_reg    <= pfail_next;
			efail_reg    <= efail_next;
			opStart_reg  <= opStart_next;
			opKind_reg   <= opKind_next;
			opPage_reg   <= opPage_next;
			drop_reg     <= drop_next;
		end
	end

	// outputs straight from registers
	assign serialDataOut   = outShift_reg[7];
	assign serialDataOutEn = outEn_reg;
	assign busy            = busy_reg;
	assign programFail     = pfail_reg;
	assign eraseFail       = efail_reg;
	assign opStart         = opStart_reg;
	assign opKind          = opKind_reg;
	assign opPageAddr      = opPage_reg;
	assign frameDropped    = drop_reg;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!reset_n);

	property p_frame_start;
		csFall |=> (state_reg == ST_OPCODE) && (bitCnt_reg == 3'h0) && (byteCnt_reg == 3'h0);
	endproperty
	a_frame_start: assert property (p_frame_start) // see (R4)
		else $error("frame not restarted");

	property p_opcode_first;
		frameActive && sclkRise && (bitCnt_reg == 3'h7) && (byteCnt_reg == 3'h0)
			|=> opcode_reg == $past(shiftNext);
	endproperty
	a_opcode_first: assert property (p_opcode_first) // see (R5)
		else $error("opcode not captured");

	property p_msb_first;
		frameActive && sclkRise && !csFall && !csRise |=> shift_reg[0] == $past(sdiSync[1]);
	endproperty
	a_msb_first: assert property (p_msb_first) // see (R6)
		else $error("bit not shifted in");

	property p_partial_drop;
		csRise && (state_reg == ST_BODY) && actsAtEnd(opcode_reg) && (bitCnt_reg != 3'h0)
			|=> !opStart && frameDropped && $stable(eraseFail) && $stable(programFail);
	endproperty
	a_partial_drop: assert property (p_partial_drop) // see (R10)
		else $error("partial frame acted");

	property p_no_protected_op;
		opStart && ((opKind == OP_ERASE) || (opKind == OP_PROGRAM)) |-> !pif.hit;
	endproperty
	a_no_protected_op: assert property (p_no_protected_op) // see (R3)
		else $error("protected op ran");

	property p_erase_fail;
		csRise && (state_reg == ST_BODY) && (opcode_reg == OPC_BLK_ERASE) && pif.hit &&
			(bitCnt_reg == 3'h0) && (byteCnt_reg >= LEN_PAGE) |=> eraseFail && !opStart;
	endproperty
	a_erase_fail: assert property (p_erase_fail) // see (R16)
		else $error("erase fail not set");

	property p_program_fail;
		csRise && (state_reg == ST_BODY) && (opcode_reg == OPC_PROG_EXEC) && pif.hit &&
			(bitCnt_reg == 3'h0) && (byteCnt_reg >= LEN_PAGE) |=> programFail && !opStart;
	endproperty
	a_program_fail: assert property (p_program_fail) // see (R15)
		else $error("program fail not set");

	property p_busy_hold;
		opStart |-> busy [*8];
	endproperty
	a_busy_hold: assert property (p_busy_hold) // see (R11)
		else $error("busy dropped early");

	// a new launch right after the drop may raise busy again
	property p_busy_end;
		busy && (busyCnt_reg == 1'b1) |=> !busy ##1 (!busy || opStart);
	endproperty
	a_busy_end: assert property (p_busy_end) // see (R17)
		else $error("busy not cleared");

	property p_busy_gate;
		frameActive && sclkRise && (bitCnt_reg == 3'h7) && (byteCnt_reg == 3'h0) && busy &&
			!allowedBusy(shiftNext) |=> (state_reg == ST_DROP) ##1 !opStart;
	endproperty
	a_busy_gate: assert property (p_busy_gate) // see (R12)
		else $error("command taken while busy");

	property p_maker_byte;
		frameActive && sclkRise && (bitCnt_reg == 3'h7) && (byteCnt_reg == 3'h1) &&
			(opcode_reg == OPC_READ_ID) |=> serialDataOutEn && (outShift_reg == MAKER_CODE);
	endproperty
	a_maker_byte: assert property (p_maker_byte) // see (R14)
		else $error("maker byte missing");

	property p_protect_none;
		pif.protectField == PROT_NONE |-> !pif.hit;
	endproperty
	a_protect_none: assert property (p_protect_none) // see (R1)
		else $error("field zero protects");

	property p_protect_all;
		pif.protectField[3] && (pif.protectField[2] || pif.protectField[1]) |-> pif.hit;
	endproperty
	a_protect_all: assert property (p_protect_all) // see (R2)
		else $error("whole array not protected");

endmodule

// File: design/snpc_pkg.sv
// constants, opcodes and helper functions for the protect and framing block
package snpc_pkg;

	// timing of the modelled internal operation
	localparam int CLK_PERIOD_NS = 40;
	localparam int OP_TIME_NS    = 8000;
	localparam int OP_CYCLES     = (OP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int OP_CNT_W      = 8;
	localparam logic [OP_CNT_W-1:0] OP_CNT_LOAD = OP_CNT_W'(OP_CYCLES);

	// array geometry and protect field layout
	localparam int BLOCK_W          = 9;
	localparam int PAGE_W           = 16;
	localparam logic [9:0] BLOCK_COUNT = 10'h200;
	localparam logic [9:0] SPAN_ONE    = 10'h001;
	localparam logic [3:0] PROT_NONE   = 4'h0;
	localparam logic [3:0] PROT_STEP   = 4'h1;

	// status reply layout
	localparam logic [3:0] SR_STATUS_SEL = 4'hC;
	localparam int PFAIL_BIT = 3;
	localparam int EFAIL_BIT = 2;
	localparam int BUSY_BIT  = 0;

	// opcodes handled by the framing logic
	localparam logic [7:0] OPC_RESET      = 8'hFF;
	localparam logic [7:0] OPC_READ_ID    = 8'h9F;
	localparam logic [7:0] OPC_RD_SR_A    = 8'h0F;
	localparam logic [7:0] OPC_RD_SR_B    = 8'h05;
	localparam logic [7:0] OPC_WR_SR_A    = 8'h1F;
	localparam logic [7:0] OPC_WR_SR_B    = 8'h01;
	localparam logic [7:0] OPC_BBM        = 8'hA1;
	localparam logic [7:0] OPC_BLK_ERASE  = 8'hD8;
	localparam logic [7:0] OPC_PROG_EXEC  = 8'h10;
	localparam logic [7:0] OPC_PAGE_READ  = 8'h13;
	localparam logic [7:0] OPC_CHIP_ER_A  = 8'hC7;
	localparam logic [7:0] OPC_CHIP_ER_B  = 8'h60;

	// byte counts of argument-carrying commands, opcode included
	localparam logic [2:0] LEN_ONE  = 3'h1;
	localparam logic [2:0] LEN_SR   = 3'h3;
	localparam logic [2:0] LEN_PAGE = 3'h4;
	localparam logic [2:0] LEN_BBM  = 3'h5;
	localparam logic [2:0] IDX_REPLY = 3'h2;

	typedef enum logic [1:0] {ST_IDLE, ST_OPCODE, ST_BODY, ST_DROP} snpc_state_t;
	typedef enum logic [2:0] {OP_NONE, OP_ERASE, OP_PROGRAM, OP_PAGE_READ, OP_BBM} snpc_op_t;

	// true for every opcode of the instruction set
	function automatic logic isKnown(input logic [7:0] op);
		case (op)
			8'hFF, 8'h9F, 8'h0F, 8'h05, 8'h1F, 8'h01, 8'h06, 8'h04, 8'hA1, 8'hA5,
			8'hA9, 8'hD8, 8'h02, 8'h84, 8'h32, 8'h34, 8'h10, 8'h13, 8'h03, 8'h0B,
			8'h0C, 8'h3B, 8'h3C, 8'h6B, 8'h6C, 8'hBB, 8'hBC, 8'hEB, 8'hEC, 8'hB9,
			8'hAB, 8'hC7, 8'h60, 8'h66, 8'h99: isKnown = 1'b1;
			default: isKnown = 1'b0;
		endcase
	endfunction

	// write, program, erase and control commands act at the closing edge
	function automatic logic actsAtEnd(input logic [7:0] op);
		case (op)
			8'hFF, 8'h1F, 8'h01, 8'h06, 8'h04, 8'hA1, 8'hD8, 8'h02, 8'h84, 8'h32,
			8'h34, 8'h10, 8'h13, 8'hC7, 8'h60, 8'h66, 8'h99, 8'hB9, 8'hAB: actsAtEnd = 1'b1;
			default: actsAtEnd = 1'b0;
		endcase
	endfunction

	// least frame length in bytes before a command may act
	function automatic logic [2:0] neededBytes(input logic [7:0] op);
		case (op)
			8'hD8, 8'h10, 8'h13: neededBytes = LEN_PAGE;
			8'hA1:               neededBytes = LEN_BBM;
			8'h1F, 8'h01:        neededBytes = LEN_SR;
			default:             neededBytes = LEN_ONE;
		endcase
	endfunction

	// the only instructions served while busy
	function automatic logic allowedBusy(input logic [7:0] op);
		allowedBusy = (op == OPC_RD_SR_A) || (op == OPC_RD_SR_B) || (op == OPC_READ_ID);
	endfunction

endpackage

// File: design/snpc_protect_decode.sv
// maps the top/bottom bit and protect field onto a protected block range
module snpc_protect_decode
	import snpc_pkg::*;
(
	snpc_protect_if.decoder pif
);

	logic [9:0] span;
	logic       allProtected;

	// range compare of the queried block against the protected span
	always_comb begin
		allProtected = pif.protectField[3] & (pif.protectField[2] | pif.protectField[1]);
		span = SPAN_ONE << (pif.protectField - PROT_STEP);
		if (pif.protectField == PROT_NONE) begin
			pif.hit = 1'b0; // see (R1)
		end else if (allProtected) begin
			pif.hit = 1'b1; // see (R2)
		end else if (pif.wholeChip) begin
			pif.hit = 1'b1;
		end else if (!pif.topBottomSelect) begin
			pif.hit = {1'b0, pif.queryBlock} >= (BLOCK_COUNT - span); // see (R1)
		end else begin
			pif.hit = {1'b0, pif.queryBlock} < span; // see (R1)
		end
	end

endmodule

// File: design/snpc_protect_if.sv
// carrier between the framing logic and the protection decoder
interface snpc_protect_if;
	import snpc_pkg::*;
	logic               topBottomSelect;
	logic [3:0]         protectField;
	logic [BLOCK_W-1:0] queryBlock;
	logic               wholeChip;
	logic               hit;
	modport decoder (input topBottomSelect, input protectField, input queryBlock,
		input wholeChip, output hit);
	modport user (output topBottomSelect, output protectField, output queryBlock,
		output wholeChip, input hit);
endinterface

// File: tb/snpc_cmd_frame_tb_top.sv
// self-checking bench for the protect and framing block
module snpc_cmd_frame_tb_top
	import snpc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [7:0]  MAKER = 8'hA6;    // arbitrary value
	localparam logic [15:0] PART  = 16'h4D19; // arbitrary value
	logic              sys_clk, reset_n, chipSelectN, serialClk, serialDataIn;
	logic              serialDataOut, serialDataOutEn, topBottomSelect;
	logic [3:0]        protectField;
	logic              busy, programFail, eraseFail, opStart, frameDropped;
	snpc_op_t          opKind, seenKind;
	logic [15:0]       opPageAddr, seenPage;
	int                nStart, nDrop, mismatches, nCompared;

	snpc_cmd_frame #(.MAKER_CODE(MAKER), .PART_CODE(PART)) i_dut (
		.sys_clk(sys_clk), .reset_n(reset_n), .chipSelectN(chipSelectN),
		.serialClk(serialClk), .serialDataIn(serialDataIn),
		.serialDataOut(serialDataOut), .serialDataOutEn(serialDataOutEn),
		.topBottomSelect(topBottomSelect), .protectFieldBit3(protectField[3]),
		.protectFieldBit2(protectField[2]), .protectFieldBit1(protectField[1]),
		.protectFieldBit0(protectField[0]), .busy(busy), .programFail(programFail),
		.eraseFail(eraseFail), .opStart(opStart), .opKind(opKind),
		.opPageAddr(opPageAddr), .frameDropped(frameDropped));

	snpc_host_model i_host (
		.sys_clk(sys_clk), .chipSelectN(chipSelectN), .serialClk(serialClk),
		.serialDataIn(serialDataIn), .serialDataOut(serialDataOut),
		.serialDataOutEn(serialDataOutEn));

	// system clock
	initial begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end

	// counts launch and drop pulses, keeps what the last launch carried
	initial begin
		nStart = 0;
		nDrop  = 0;
	end
	always @(negedge sys_clk) begin
		if (opStart === 1'b1) begin
			nStart++;
			seenKind = opKind;
			seenPage = opPageAddr;
		end
		if (frameDropped === 1'b1) begin
			nDrop++;
		end
	end

	// number of protected blocks for a field code
	function automatic int spanOf(input logic [3:0] f);
		spanOf = (f == 4'h0) ? 0 : (f > 4'h9) ? 512 : 1 << (f - 4'h1);
	endfunction

	// true when the block lies in the protected range
	function automatic logic isProt(input logic t, input logic [3:0] f, input int blk);
		isProt = t ? (blk < spanOf(f)) : (blk >= 512 - spanOf(f));
	endfunction

	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
		nCompared++;
		if (seen !== exp) begin
			mismatches++;
			$display("wrong value at %0t: %s seen %0h expected %0h", $time, what, seen, exp);
		end
	endtask

	task automatic endTest(input string name);
		$display("test %s done", name);
	endtask

	task automatic report_and_stop();
		$display("compared %0d mismatches %0d", nCompared, mismatches);
		if (mismatches == 0 && nCompared > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// bounded wait for busy to fall, with a floor on how long it stood
	task automatic waitIdle(input int lo);
		int n;
		n = 0;
		while (busy !== 1'b0 && n < 400) begin
			@(negedge sys_clk);
			n++;
		end
		if (n == 400) begin
			mismatches++;
			$display("wrong value at %0t: busy never fell", $time);
			report_and_stop();
		end
		check(n >= lo && n <= OP_CYCLES, 1'b1, "busy time");
	endtask

	// frame expecting ds drops and no launch
	task automatic frame(input logic [47:0] d, input int nb, input int ds,
		output logic [31:0] rx);
		int s0;
		int d0;
		s0 = nStart;
		d0 = nDrop;
		i_host.xfer(d, nb, rx);
		check(nDrop - d0, ds, "drops");
		check(nStart - s0, 0, "launches");
	endtask

	// erase or program, launched or refused by protection
	task automatic doOp(input logic [7:0] opc, input logic [15:0] pa);
		logic        hit;
		logic [31:0] rx;
		int          s0;
		hit = isProt(topBottomSelect, protectField, int'(pa[14:6]));
		s0 = nStart;
		i_host.xfer({opc, 8'h00, pa, 16'h0000}, 32, rx);
		check(nStart - s0, {31'h0, !hit}, "launch");
		if (hit) begin
			check(opc == OPC_PROG_EXEC ? programFail : eraseFail, 1'b1, "fail");
		end else begin
			check(seenKind, opc == OPC_PROG_EXEC ? OP_PROGRAM : OP_ERASE, "kind");
			check(seenPage, pa, "page");
			waitIdle(OP_CYCLES - 20);
		end
	endtask

	// main sequence
	initial begin
		logic [31:0] rx;
		logic [8:0]  blk;
		int          e;
		reset_n         = 1'b0;
		topBottomSelect = 1'b0;
		protectField    = 4'h0;
		mismatches      = 0;
		nCompared       = 0;
		void'($urandom(32'h2CC44B46));
		repeat (2) @(negedge sys_clk);
		reset_n = 1'b1;
		repeat (3) @(negedge sys_clk);
		// every code at both ends, block just inside or outside the edge
		for (int c = 0; c < 32; c++) begin
			topBottomSelect = c[4];
			protectField    = c[3:0];
			e   = c[4] ? spanOf(c[3:0]) : 512 - spanOf(c[3:0]);
			blk = 9'(e) - 9'($urandom_range(1, 0));
			doOp($urandom_range(1, 0) ? OPC_BLK_ERASE : OPC_PROG_EXEC,
				{1'b0, blk, 6'($urandom)});
		end
		// whole array still protected: both fail flags must show in the status reply
		doOp(OPC_BLK_ERASE, 16'h7FC0);
		doOp(OPC_PROG_EXEC, 16'h7FC0);
		frame({OPC_RD_SR_A, 8'hC0, 32'h0}, 24, 0, rx);
		check(rx[7:0], 8'h0C, "status");
		frame({OPC_RESET, 40'h0}, 8, 0, rx);
		check({programFail, eraseFail}, 2'b00, "flags cleared");
		endTest("protect table");
		// short, off-boundary and unknown frames
		protectField = 4'h0;
		frame({OPC_BLK_ERASE, 40'h0}, 31, 1, rx);
		frame({OPC_PROG_EXEC, 40'h0}, 24, 1, rx);
		frame({OPC_WR_SR_A, 40'h0}, 16, 1, rx);
		frame({8'h00, 40'h0}, 8, 1, rx);
		frame({OPC_READ_ID, 40'h0}, 21, 0, rx);
		topBottomSelect = 1'($urandom);
		protectField    = 4'($urandom);
		frame({OPC_RD_SR_B, 8'hA0, 32'h0}, 24, 0, rx);
		check(rx[7:0], {1'b0, protectField, topBottomSelect, 2'b00}, "field");
		endTest("refusal");
		// page read and block swap launch with no protection check
		protectField = 4'hF;
		i_host.xfer({OPC_PAGE_READ, 8'h00, 16'h7FC0, 16'h0000}, 32, rx);
		check(seenKind, OP_PAGE_READ, "page read");
		check(seenPage, 16'h7FC0, "read page");
		waitIdle(OP_CYCLES - 20);
		i_host.xfer({OPC_BBM, 16'h01FF, 16'h0000, 8'h00}, 40, rx);
		check(seenKind, OP_BBM, "swap");
		check(seenPage, 16'h01FF, "swap block");
		waitIdle(OP_CYCLES - 20);
		endTest("launch kinds");
		// busy gating
		protectField = 4'h0;
		doOp(OPC_BLK_ERASE, 16'h0040);
		i_host.xfer({OPC_BLK_ERASE, 8'h00, 16'h0080, 16'h0000}, 32, rx);
		check(busy, 1'b1, "busy");
		frame({OPC_READ_ID, 40'h0}, 40, 0, rx);
		check(rx[23:0], {MAKER, PART}, "id");
		waitIdle(0);
		i_host.xfer({OPC_PROG_EXEC, 8'h00, 16'h0100, 16'h0000}, 32, rx);
		frame({OPC_BLK_ERASE, 8'h00, 16'h0140, 16'h0000}, 32, 1, rx);
		waitIdle(0);
		endTest("busy");
		report_and_stop();
	end
endmodule

// File: tb/snpc_host_model.sv
// host serial controller model that frames instructions into the device
module snpc_host_model (
	input  wire logic sys_clk,
	output logic      chipSelectN,
	output logic      serialClk,
	output logic      serialDataIn,
	input  wire logic serialDataOut,
	input  wire logic serialDataOutEn
);
	timeunit 1ns;
	timeprecision 1ns;

	// idle bus: frame strobe high, serial clock parked low
	initial begin
		chipSelectN  = 1'b1;
		serialClk    = 1'b0;
		serialDataIn = 1'b0;
	end

	// one frame of nb bits of d, reply bits shifted into rx while driven
	task automatic xfer(input logic [47:0] d, input int nb, output logic [31:0] rx);
		rx = 32'h0;
		@(negedge sys_clk);
		chipSelectN  = 1'b0;
		serialDataIn = d[47];
		for (int i = 0; i < nb; i++) begin
			repeat (4) @(negedge sys_clk);
			serialClk = 1'b1;
			repeat (2) @(negedge sys_clk);
			if (serialDataOutEn === 1'b1) begin
				rx = {rx[30:0], serialDataOut};
			end
			repeat (2) @(negedge sys_clk);
			serialClk = 1'b0;
			// released line shows the inverse, not a stale bit
			serialDataIn = (i + 1 < nb) ? d[46-i] : ~d[47-i];
		end
		repeat (4) @(negedge sys_clk);
		chipSelectN = 1'b1;
		repeat (8) @(negedge sys_clk);
	endtask
endmodule
